// ---- logic/disp_cmd_ram.sv ----
// Purpose: command interpreter and frame memory of a passive-matrix display controller
// Assumes: host bytes already deserialised by the serial front end in sys_clk domain
// Notes: reset_n pin passes three flops; rst_n is the synchronous system reset
`timescale 1ns/1ns
`default_nettype none
module disp_cmd_ram
    import disp_pkg::*;
(
    input wire logic sys_clk,            // 20 MHz system clock
    input wire logic rst_n,              // synchronous reset, active low
    input wire logic reset_n,            // external reset pin, asynchronous to clock
    input wire logic bus_select,         // strap: high I2C, low serial
    input wire logic slave_addr_low_bit, // I2C low address bit / serial d/c level
    input wire host_byte_t host_in,      // byte from front end, tagged data or command
    input wire scan_req_t scan_in,       // panel scan position
    output logic [5:0] addr_base,        // I2C 7-bit address lower six bits compare
    output logic pixel_out,              // pixel for scan position, one cycle late
    output logic drive_en,               // row and column drivers enabled
    output logic pump_en,                // charge pump enabled
    output logic [6:0] col_ptr,          // current column pointer
    output logic [2:0] page_ptr          // current page pointer
);
    logic [7:0] frame_ram [NUM_PAGES*NUM_COLS];
    disp_state_t s_r, s_nxt;
    logic init;
    logic pin_low;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [9:0] rd_addr;
    logic [7:0] rd_byte;
    logic [5:0] row_mem;

    // physical column for a logical column, honouring column remap
    function automatic logic [6:0] map_col(input logic [6:0] c, input logic rev);
        map_col = rev ? 7'(7'h7F - c) : c;
    endfunction : map_col

    // reset pin after three flops; a level counts once stages two and three agree
    // while they disagree the last agreed level in rs_live holds, filtering glitches
    assign pin_low = (s_r.rs_sync[2] == s_r.rs_sync[1]) ? !s_r.rs_sync[1] : !s_r.rs_live;
    assign init = !rst_n || pin_low;
    // only bytes tagged data reach the frame memory
    assign wr_en = host_in.valid && host_in.is_data && !init;
    assign wr_addr = {s_r.page, map_col(s_r.col, s_r.col_rev)};
    // scan row shifted by start line and offset, row remap
    always_comb begin
        row_mem = 6'(scan_in.row + s_r.start_line + s_r.offset);
        if (s_r.row_rev) begin
            row_mem = 6'(6'h3F - row_mem);
        end
    end
    assign rd_addr = {row_mem[5:3], map_col(scan_in.col, s_r.col_rev)};
    assign rd_byte = frame_ram[rd_addr];

    // frame memory write port
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            frame_ram[wr_addr] <= host_in.value;
        end
    end

    // next-state of the command interpreter
    always_comb begin
        s_nxt = s_r;
        s_nxt.rs_sync = {s_r.rs_sync[1:0], reset_n};
        s_nxt.pix = rd_byte[row_mem[2:0]];
        if (s_r.disp_on_cmd && !s_r.drive_on) begin
            if (s_r.on_cnt == 22'(DISPLAY_ON_DELAY_CYC - 1)) begin
                s_nxt.drive_on = 1'b1;
            end else begin
                s_nxt.on_cnt = 22'(s_r.on_cnt + 22'h000001);
            end
        end
        if (wr_en) begin
            s_nxt.col = 7'(s_r.col + 7'h01);
        end
        if (host_in.valid && !host_in.is_data) begin
            case (s_r.arg)
                ST_OFFSET_ARG: begin
                    s_nxt.offset = host_in.value[5:0];
                    s_nxt.arg = ST_IDLE;
                end
                ST_PUMP_ARG: begin
                    s_nxt.pump_on = host_in.value[2];
                    s_nxt.arg = ST_IDLE;
                end
                ST_IDLE: begin
                    if (host_in.value == CMD_DISP_ON) begin
                        s_nxt.disp_on_cmd = 1'b1;
                        s_nxt.on_cnt = 22'h000000;
                    end else if (host_in.value == CMD_DISP_OFF) begin
                        s_nxt.disp_on_cmd = 1'b0;
                        s_nxt.drive_on = 1'b0;
                    end else if (host_in.value == CMD_PUMP) begin
                        s_nxt.arg = ST_PUMP_ARG;
                    end else if (host_in.value == CMD_OFFSET) begin
                        s_nxt.arg = ST_OFFSET_ARG;
                    end else if (host_in.value == CMD_SEG_NORM) begin
                        s_nxt.col_rev = 1'b0;
                    end else if (host_in.value == CMD_SEG_REV) begin
                        s_nxt.col_rev = 1'b1;
                    end else if (host_in.value == CMD_ROW_NORM) begin
                        s_nxt.row_rev = 1'b0;
                    end else if (host_in.value == CMD_ROW_REV) begin
                        s_nxt.row_rev = 1'b1;
                    end else if (host_in.value[7:3] == CMD_PAGE_HI) begin
                        s_nxt.page = host_in.value[2:0];
                    end else if (host_in.value[7:4] == CMD_COL_LO_HI) begin
                        s_nxt.col = {s_r.col[6:4], host_in.value[3:0]};
                    end else if (host_in.value[7:4] == CMD_COL_HI_HI) begin
                        s_nxt.col = {host_in.value[2:0], s_r.col[3:0]};
                    end else if (host_in.value[7:6] == CMD_START_HI) begin
                        s_nxt.start_line = host_in.value[5:0];
                    end
                end
                default: begin
                    s_nxt.arg = ST_IDLE;
                end
            endcase
        end
        if (init) begin
            s_nxt.arg = ST_IDLE;
            s_nxt.col = RST_COL;
            s_nxt.page = RST_PAGE;
            s_nxt.start_line = RST_START;
            s_nxt.offset = RST_OFFSET;
            s_nxt.row_rev = 1'b0;
            s_nxt.col_rev = 1'b0;
            s_nxt.disp_on_cmd = 1'b0;
            s_nxt.pump_on = 1'b0;
            s_nxt.on_cnt = 22'h000000;
            s_nxt.drive_on = 1'b0;
        end
        // synchroniser and agreed level start at the pin's idle high level
        if (!rst_n) begin
            s_nxt.rs_sync = 3'h7;
            s_nxt.pix = 1'b0;
            s_nxt.rs_live = 1'b1;
        end else begin
            s_nxt.rs_live = !pin_low;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        s_r <= s_nxt;
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_base <= 6'h00;
        end else begin
            addr_base <= {5'h1E, slave_addr_low_bit};
        end
    end
    assign pixel_out = s_r.pix;
    assign drive_en = s_r.drive_on;
    assign pump_en = s_r.pump_on;
    assign col_ptr = s_r.col;
    assign page_ptr = s_r.page;

    logic unused_strap;
    assign unused_strap = bus_select ^ s_r.rs_live; // strap seen by front end

    // assertions
    a_data_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_en |=> col_ptr == 7'($past(col_ptr) + 7'h01))
        else $error("column pointer did not advance on data");
    a_on_delay_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(s_r.disp_on_cmd) |-> !drive_en [*8])
        else $error("drivers enabled too early");
    a_reset_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_r.rs_sync[2:1] == 2'b00) |=> !drive_en && !pump_en && col_ptr == RST_COL)
        else $error("reset did not restore defaults");
    a_page_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!init && host_in.valid && !host_in.is_data && s_r.arg == ST_IDLE
         && host_in.value[7:3] == CMD_PAGE_HI) |=> page_ptr == $past(host_in.value[2:0]))
        else $error("page command not applied");
    a_pump_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!init && host_in.valid && !host_in.is_data && s_r.arg == ST_PUMP_ARG
         && host_in.value == 8'h10) |=> !pump_en)
        else $error("pump not disabled");
    a_off_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (host_in.valid && !host_in.is_data && s_r.arg == ST_IDLE
         && host_in.value == CMD_DISP_OFF) |=> !drive_en)
        else $error("display off did not stop drivers");
    a_col_rev: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_r.col_rev |-> wr_addr[6:0] == 7'(7'h7F - s_r.col))
        else $error("column remap wrong");
    a_no_cmd_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (host_in.valid && !host_in.is_data) |-> !wr_en)
        else $error("command byte written to memory");

    // display-on byte taken while idle and out of reset
    sequence seq_on_taken;
        !init && host_in.valid && !host_in.is_data && s_r.arg == ST_IDLE
            && host_in.value == CMD_DISP_ON;
    endsequence

    // delay count restarts from zero with the flag set
    sequence seq_count_started;
        s_r.disp_on_cmd && s_r.on_cnt == 22'h000000;
    endsequence

    a_on_starts_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_on_taken |=> seq_count_started)
        else $error("display on did not start the delay count");
    a_on_count_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(drive_en) |-> $past(s_r.on_cnt) == 22'(DISPLAY_ON_DELAY_CYC - 1))
        else $error("drivers enabled before the full delay");
    a_defaults_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init |=> page_ptr == RST_PAGE && s_r.start_line == RST_START
            && s_r.offset == RST_OFFSET && !s_r.row_rev && !s_r.col_rev && s_r.arg == ST_IDLE)
        else $error("reset pin did not restore mapping registers");
endmodule : disp_cmd_ram
`default_nettype wire

// ---- logic/disp_pkg.sv ----
// Purpose: shared constants and carrier types for the display command block
// Assumes: 20 MHz sys_clk, one clock domain
// Notes: command codes and timing counts used by the command interpreter
package disp_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int DISPLAY_ON_DELAY_MS = 100;
    localparam int DISPLAY_ON_DELAY_CYC = (CLK_HZ / 1000) * DISPLAY_ON_DELAY_MS;
    localparam int NUM_COLS = 128;
    localparam int NUM_PAGES = 8;
    localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON = 8'hAF;
    localparam logic [7:0] CMD_PUMP = 8'h8D;
    localparam logic [7:0] CMD_OFFSET = 8'hD3;
    localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
    localparam logic [7:0] CMD_SEG_REV = 8'hA1;
    localparam logic [7:0] CMD_ROW_NORM = 8'hC0;
    localparam logic [7:0] CMD_ROW_REV = 8'hC8;
    localparam logic [4:0] CMD_PAGE_HI = 5'h16;
    localparam logic [3:0] CMD_COL_LO_HI = 4'h0;
    localparam logic [3:0] CMD_COL_HI_HI = 4'h1;
    localparam logic [1:0] CMD_START_HI = 2'h1;
    localparam logic [6:0] RST_COL = 7'h00;
    localparam logic [2:0] RST_PAGE = 3'h0;
    localparam logic [5:0] RST_START = 6'h00;
    localparam logic [5:0] RST_OFFSET = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OFFSET_ARG = 2'b01,
        ST_PUMP_ARG = 2'b10
    } arg_state_t;

    typedef struct packed {
        logic valid;
        logic is_data;
        logic [7:0] value;
    } host_byte_t;

    typedef struct packed {
        logic [5:0] row;
        logic [6:0] col;
    } scan_req_t;

    typedef struct packed {
        arg_state_t arg;
        logic [6:0] col;
        logic [2:0] page;
        logic [5:0] start_line;
        logic [5:0] offset;
        logic row_rev;
        logic col_rev;
        logic disp_on_cmd;
        logic pump_on;
        logic [21:0] on_cnt;
        logic drive_on;
        logic pix;
        logic [2:0] rs_sync;
        logic rs_live;
    } disp_state_t;
endpackage : disp_pkg

// ---- testbench/host_model.sv ----
// Purpose: host controller model that hands command and data bytes to the block
// Assumes: one byte per sys_clk cycle at most, driven just after the rising edge
// Notes: the bench calls send and idle hierarchically; valid stays up back to back
`timescale 1ns/1ns
`default_nettype none
module host_model
    import disp_pkg::*;
(
    input wire logic sys_clk,       // 20 MHz system clock
    output var host_byte_t host_out // byte toward the block
);
    // bus starts idle so nothing is taken during reset
    // link pins and chip select are wired at the board; bytes arrive already parallel
    initial host_out = '0;

    // one byte per edge; command or data tag travels with it
    task automatic send(input logic is_data, input logic [7:0] value);
        @(posedge sys_clk);
        host_out <= '{valid: 1'b1, is_data: is_data, value: value};
    endtask : send

    // drop valid at the next edge, never in the same step as a send
    task automatic idle();
        @(posedge sys_clk);
        host_out <= '0;
    endtask : idle
endmodule : host_model
`default_nettype wire

// ---- testbench/oled_host_cmd_and_frame_ram_test.sv ----
// Purpose: self-checking bench for the display command interpreter and frame memory
// Assumes: 20 MHz clock, synchronous rst_n, reset_n released after rst_n
// Notes: the 100 ms display-on delay is too long to run; only its early quiet part is seen
// Notes: the supply settle wait is not modelled; reset_n is held low for 3 us
`timescale 1ns/1ns
`default_nettype none
module oled_host_cmd_and_frame_ram_test;
    import disp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset_n = 1'b0;
    logic bus_select = 1'b1;
    logic sa_bit = 1'b0;
    scan_req_t scan_in = '0;
    host_byte_t host_in;
    logic [5:0] addr_base;
    logic pixel_out, drive_en, pump_en;
    logic [6:0] col_ptr;
    logic [2:0] page_ptr;
    int err_total = 0;
    int checks_done = 0;

    // free-running system clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    host_model i_host_model (.sys_clk(sys_clk), .host_out(host_in));

    disp_cmd_ram i_disp_cmd_ram (.sys_clk(sys_clk), .rst_n(rst_n), .reset_n(reset_n),
        .bus_select(bus_select), .slave_addr_low_bit(sa_bit), .host_in(host_in),
        .scan_in(scan_in), .addr_base(addr_base), .pixel_out(pixel_out),
        .drive_en(drive_en), .pump_en(pump_en), .col_ptr(col_ptr), .page_ptr(page_ptr));

    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cmd(input logic [7:0] v);
        i_host_model.send(1'b0, v);
    endtask : cmd

    // end a burst and let the last byte land
    task automatic settle();
        i_host_model.idle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic pix(input logic [5:0] row, input logic [6:0] col, input logic exp);
        @(posedge sys_clk);
        scan_in <= '{row: row, col: col};
        repeat (2) @(posedge sys_clk);
        #1;
        check("pixel_out", {7'h00, pixel_out}, {7'h00, exp});
    endtask : pix

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (50) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        check("addr_base", {2'h0, addr_base}, 8'h3C);
        @(posedge sys_clk);
        sa_bit <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check("addr_base", {2'h0, addr_base}, 8'h3D);
        check("col_ptr", {1'b0, col_ptr}, 8'h00);
        // page and column set, then one data byte
        cmd(8'hB3);
        cmd(8'h05);
        cmd(8'h12);
        settle();
        check("page_ptr", {5'h00, page_ptr}, 8'h03);
        check("col_ptr", {1'b0, col_ptr}, 8'h25);
        i_host_model.send(1'b1, 8'h81);
        settle();
        check("col_ptr", {1'b0, col_ptr}, 8'h26);
        pix(6'd24, 7'h25, 1'b1);
        pix(6'd25, 7'h25, 1'b0);
        pix(6'd31, 7'h25, 1'b1);
        cmd(8'hA1);
        settle();
        pix(6'd24, 7'h5A, 1'b1);
        cmd(8'hA0);
        cmd(8'hC8);
        settle();
        pix(6'd39, 7'h25, 1'b1);
        cmd(8'hC0);
        cmd(8'h41);
        settle();
        pix(6'd23, 7'h25, 1'b1);
        cmd(8'hD3);
        cmd(8'h01);
        settle();
        pix(6'd22, 7'h25, 1'b1);
        // power on: pump then display on
        cmd(8'h8D);
        cmd(8'h14);
        cmd(8'hAF);
        settle();
        check("pump_en", {7'h00, pump_en}, 8'h01);
        for (int i = 0; i < 1000; i++) begin
            @(posedge sys_clk);
            if (drive_en !== 1'b0) break;
        end
        #1;
        check("drive_en", {7'h00, drive_en}, 8'h00);
        // power off: display off then pump disable
        cmd(8'hAE);
        cmd(8'h8D);
        cmd(8'h10);
        settle();
        check("pump_en", {7'h00, pump_en}, 8'h00);
        // device reset pin returns pointers, pump and mapping to defaults
        cmd(8'h8D);
        cmd(8'h14);
        cmd(8'hB5);
        settle();
        check("pump_en", {7'h00, pump_en}, 8'h01);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (60) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check("page_ptr", {5'h00, page_ptr}, 8'h00);
        check("pump_en", {7'h00, pump_en}, 8'h00);
        check("col_ptr", {1'b0, col_ptr}, 8'h00);
        pix(6'd24, 7'h25, 1'b1);
        print_verdict();
    end
endmodule : oled_host_cmd_and_frame_ram_test
`default_nettype wire
